// [hw/plcc_pkg.sv]
// constants for the link capability and link control register bank
package plcc_pkg;
  localparam logic [7:0] LINK_CAP_OFS = 8'hbc;
  localparam logic [7:0] LINK_CTL_OFS = 8'hc0;
  // link capability fields
  localparam logic [3:0] SPEED_2G5 = 4'h1;
  localparam logic [5:0] WIDTH_X1 = 6'h01;
  localparam logic [1:0] ASPM_SUP_BOTH = 2'h3;
  localparam logic [2:0] L0S_EXIT_LAT = 3'h3;
  localparam logic [2:0] L1_EXIT_OFF = 3'h0;
  localparam logic [2:0] L1_EXIT_ON = 3'h6;
  localparam logic [7:0] PORT_NUM = 8'h00;
  // link control bit positions
  localparam int ASPM_LO = 0;
  localparam int RCB_BIT = 3;
  localparam int CCC_BIT = 6;
  localparam int ESYNC_BIT = 7;
  localparam int CPM_EN_BIT = 8;
  // strap pins that must both be low to turn on clock power management
  localparam logic [1:0] STRAP_ON = 2'h0;
  localparam logic [1:0] ASPM_CTL_RST = 2'h0;
endpackage

// [hw/plcc_strap.sv]
// strap catcher for the clock power management enable
`timescale 1ns/1ps
module plcc_strap (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] strap_pins,
  output logic cpm_on
);
  logic armed_reg;
  logic cpm_reg;

  // the strap is caught on the first clock after reset release, never under reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      armed_reg <= 1'b1;
      cpm_reg <= 1'b0;
    end
    else if (armed_reg)
    begin
      armed_reg <= 1'b0;
      cpm_reg <= (strap_pins == plcc_pkg::STRAP_ON);
    end
  end

  assign cpm_on = cpm_reg;

  a_strap_once: assert property (@(posedge clk) disable iff (sys_rst)
    !armed_reg |=> $stable(cpm_reg))
    else $error("strap value changed after capture");
endmodule

// [hw/plcc_bit.sv]
// one read-write storage bit with an optional write gate
`timescale 1ns/1ps
module plcc_bit #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic wr_val,
  output logic q
);
  logic bit_reg;

  // storage updates only when the decoded write hits this bit
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      bit_reg <= RST_VAL;
    else if (wr_en)
      bit_reg <= wr_val;
  end

  assign q = bit_reg;
endmodule

// [hw/plcc_regs.sv]
// link capability and link control register bank
// Function
// - speed field 3:0 reads 0001, 2.5 Gb/s
// - width field 9:4 one-hot, reads x1
// - ASPM support 11:10 reads 11
// - L1 exit latency 0h or 6h
// - clock PM capable bit follows strap
// - strap enables when both pins low
// - ASPM control 1:0 writable, reset 00
// - completion boundary bit 3 reads zero
// - clock PM enable writable only if strapped
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module plcc_regs #(
  parameter logic [5:0] MAX_WIDTH = plcc_pkg::WIDTH_X1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] strap_pins,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic [1:0] aspm_ctl,
  output logic common_clk,
  output logic ext_sync,
  output logic cpm_enable,
  output logic cpm_capable
);
  logic cpm_on;
  logic [1:0] aspm_reg;
  logic ccc_q;
  logic esync_q;
  logic cpm_en_q;
  logic [31:0] rdata_reg;
  logic [1:0] aspm_o_reg;
  logic ccc_o_reg;
  logic esync_o_reg;
  logic cpm_en_o_reg;
  logic cap_o_reg;

  plcc_strap u_strap (
    .clk(clk),
    .sys_rst(sys_rst),
    .strap_pins(strap_pins),
    .cpm_on(cpm_on)
  );

  // address decode
  wire hit_cap = (addr == plcc_pkg::LINK_CAP_OFS);
  wire hit_ctl = (addr == plcc_pkg::LINK_CTL_OFS);
  wire wr_ctl = wr && hit_ctl;
  wire cpm_wr = wr_ctl && cpm_on;

  // capability word, built from constants and the strap only
  wire [2:0] l1_lat = cpm_on ? plcc_pkg::L1_EXIT_ON : plcc_pkg::L1_EXIT_OFF;
  wire [31:0] cap_word = {plcc_pkg::PORT_NUM, 3'h0, 1'b0, 1'b0,
                          cpm_on,
                          l1_lat,
                          plcc_pkg::L0S_EXIT_LAT,
                          plcc_pkg::ASPM_SUP_BOTH,
                          MAX_WIDTH,
                          plcc_pkg::SPEED_2G5};
  // control word: bits 2,4,5 and 15:9 tie to zero, bit 3 too
  wire [31:0] ctl_word = {16'h0000, 7'h00, cpm_en_q, esync_q, ccc_q, 2'h0,
                          1'b0,
                          1'b0, aspm_reg};
  wire [31:0] rd_mux = hit_cap ? cap_word : (hit_ctl ? ctl_word : 32'h00000000);

  // ASPM control field; only two bits stored, other bits of the write dropped
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      aspm_reg <= plcc_pkg::ASPM_CTL_RST;
    else if (wr_ctl)
      aspm_reg <= wdata[plcc_pkg::ASPM_LO +: 2];
  end

  plcc_bit u_ccc (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(wr_ctl),
    .wr_val(wdata[plcc_pkg::CCC_BIT]),
    .q(ccc_q)
  );

  plcc_bit u_esync (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(wr_ctl),
    .wr_val(wdata[plcc_pkg::ESYNC_BIT]),
    .q(esync_q)
  );

  // write gated by the strap: read-only when clock PM is off
  plcc_bit u_cpm (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(cpm_wr),
    .wr_val(wdata[plcc_pkg::CPM_EN_BIT]),
    .q(cpm_en_q)
  );

  // read data one cycle after the strobe, zero otherwise; outputs registered
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdata_reg <= 32'h00000000;
      aspm_o_reg <= 2'h0;
      ccc_o_reg <= 1'b0;
      esync_o_reg <= 1'b0;
      cpm_en_o_reg <= 1'b0;
      cap_o_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rd ? rd_mux : 32'h00000000;
      aspm_o_reg <= aspm_reg;
      ccc_o_reg <= ccc_q;
      esync_o_reg <= esync_q;
      cpm_en_o_reg <= cpm_en_q;
      cap_o_reg <= cpm_on;
    end
  end

  assign rdata = rdata_reg;
  assign aspm_ctl = aspm_o_reg;
  assign common_clk = ccc_o_reg;
  assign ext_sync = esync_o_reg;
  assign cpm_enable = cpm_en_o_reg;
  assign cpm_capable = cap_o_reg;

  // checks: read checks look one cycle past the strobe, where the
  // registered read data stand; a read in the capture cycle right after
  // reset would still see the strap as off, its reset value, so software waits one more edge

  // capability word, one field at a time
  // speed code is fixed at the single supported rate
  a_speed_code: assert property (@(posedge clk) disable iff (sys_rst)
    rd && hit_cap |=> rdata[3:0] == plcc_pkg::SPEED_2G5)
    else $error("link speed code wrong");

  // width code must be a legal one-hot pattern
  a_width_code: assert property (@(posedge clk) disable iff (sys_rst)
    rd && hit_cap |=> $onehot(rdata[9:4]))
    else $error("width field not one-hot");

  // width code must be the configured maximum
  a_width_value: assert property (@(posedge clk) disable iff (sys_rst)
    rd && hit_cap |=> rdata[9:4] == MAX_WIDTH)
    else $error("width field not the configured maximum");

  // both low power states are always advertised
  a_aspm_support: assert property (@(posedge clk) disable iff (sys_rst)
    rd && hit_cap |=> rdata[11:10] == plcc_pkg::ASPM_SUP_BOTH)
    else $error("ASPM support not 11");

  // latency follows the strap whichever way it went
  a_l1_latency: assert property (@(posedge clk) disable iff (sys_rst)
    rd && hit_cap |=> rdata[17:15] == (cpm_on ? plcc_pkg::L1_EXIT_ON : plcc_pkg::L1_EXIT_OFF))
    else $error("L1 exit latency mismatch");

  // strap off: latency must read as zero
  a_l1_off: assert property (@(posedge clk) disable iff (sys_rst)
    rd && hit_cap && !cpm_on |=> rdata[17:15] == plcc_pkg::L1_EXIT_OFF)
    else $error("L1 exit latency not zero with strap off");

  // strap on: latency must read as the enabled value
  a_l1_on: assert property (@(posedge clk) disable iff (sys_rst)
    rd && hit_cap && cpm_on |=> rdata[17:15] == plcc_pkg::L1_EXIT_ON)
    else $error("L1 exit latency wrong with strap on");

  // capable bit in the word tracks the caught strap
  a_cpm_capable: assert property (@(posedge clk) disable iff (sys_rst)
    rd && hit_cap |=> rdata[18] == cpm_on)
    else $error("clock PM capable mismatch");

  // capable pin is the strap result one register later
  a_cap_mirror: assert property (@(posedge clk) disable iff (sys_rst)
    cpm_capable == $past(cpm_on))
    else $error("clock PM capable pin does not follow strap");

  // upper capability bits: reserved and port number read zero
  a_cap_resv: assert property (@(posedge clk) disable iff (sys_rst)
    rd && hit_cap |=> rdata[31:19] == 13'h0000)
    else $error("reserved capability bits nonzero");

  // control word storage and read back
  // a control write lands in the two stored bits
  a_aspm_write: assert property (@(posedge clk) disable iff (sys_rst)
    wr_ctl |=> aspm_reg == $past(wdata[1:0]))
    else $error("ASPM control write lost");

  // without a control write the field must not drift
  a_aspm_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !wr_ctl |=> $stable(aspm_reg))
    else $error("ASPM control changed without a write");

  // under reset the field sits at its reset code
  a_aspm_reset: assert property (@(posedge clk)
    sys_rst |-> aspm_reg == plcc_pkg::ASPM_CTL_RST)
    else $error("ASPM control not at reset value");

  // completion boundary is never supported
  a_rcb_zero: assert property (@(posedge clk) disable iff (sys_rst)
    rd && hit_ctl |=> rdata[plcc_pkg::RCB_BIT] == 1'b0)
    else $error("completion boundary bit set");

  // even right after a write of ones it must read zero
  a_rcb_write: assert property (@(posedge clk) disable iff (sys_rst)
    wr_ctl ##1 (rd && hit_ctl) |=> rdata[plcc_pkg::RCB_BIT] == 1'b0)
    else $error("completion boundary bit took a write");

  // without the strap the enable bit can never rise
  a_cpm_locked: assert property (@(posedge clk) disable iff (sys_rst)
    !cpm_on |=> !cpm_en_q)
    else $error("clock PM enable set while not strapped");

  // with the strap a control write lands in the enable bit
  a_cpm_write: assert property (@(posedge clk) disable iff (sys_rst)
    cpm_wr |=> cpm_en_q == $past(wdata[plcc_pkg::CPM_EN_BIT]))
    else $error("clock PM enable write lost");

  // no gated write, no change
  a_cpm_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !cpm_wr |=> $stable(cpm_en_q))
    else $error("clock PM enable changed without a write");

  // reserved control bits read zero
  a_resv_zero: assert property (@(posedge clk) disable iff (sys_rst)
    rd && hit_ctl |=> rdata[31:9] == 23'h0 && rdata[5:4] == 2'h0 && !rdata[2])
    else $error("reserved control bits nonzero");

  // control is a 16-bit register, the upper half reads zero
  a_ctl_upper: assert property (@(posedge clk) disable iff (sys_rst)
    rd && hit_ctl |=> rdata[31:16] == 16'h0000)
    else $error("upper half of control word nonzero");

  // unmapped addresses read as zero
  a_unmapped_zero: assert property (@(posedge clk) disable iff (sys_rst)
    rd && !hit_cap && !hit_ctl |=> rdata == 32'h00000000)
    else $error("unmapped read returned data");

  // read data stand for one cycle only, zero otherwise
  a_idle_zero: assert property (@(posedge clk) disable iff (sys_rst)
    !rd |=> rdata == 32'h00000000)
    else $error("read data present without a read");

  // a write to the capability word leaves all storage alone
  a_cap_nowrite: assert property (@(posedge clk) disable iff (sys_rst)
    wr && hit_cap |=> $stable(aspm_reg) && $stable(ccc_q) && $stable(esync_q) && $stable(cpm_en_q))
    else $error("capability write changed storage");

  // stored common clock bit survives an idle cycle
  a_ccc_store: assert property (@(posedge clk) disable iff (sys_rst)
    wr_ctl ##1 !wr_ctl |=> ccc_q == $past(wdata[plcc_pkg::CCC_BIT], 2))
    else $error("common clock bit not stored");

  // common clock bit takes the written value
  a_ccc_write: assert property (@(posedge clk) disable iff (sys_rst)
    wr_ctl |=> ccc_q == $past(wdata[plcc_pkg::CCC_BIT]))
    else $error("common clock write lost");

  // extended sync bit takes the written value
  a_esync_write: assert property (@(posedge clk) disable iff (sys_rst)
    wr_ctl |=> esync_q == $past(wdata[plcc_pkg::ESYNC_BIT]))
    else $error("extended sync write lost");

  // extended sync bit holds without a write
  a_esync_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !wr_ctl |=> $stable(esync_q))
    else $error("extended sync changed without a write");

  // both plain storage bits are clear under reset
  a_ccc_reset: assert property (@(posedge clk)
    sys_rst |-> !ccc_q && !esync_q)
    else $error("storage bits not clear under reset");

  // output pins: registered copies, one cycle behind storage
  // ASPM control pins follow the stored field
  a_mirror_aspm: assert property (@(posedge clk) disable iff (sys_rst)
    aspm_ctl == $past(aspm_reg))
    else $error("ASPM control pins do not follow storage");

  // the three single-bit control pins follow their storage
  a_mirror_bits: assert property (@(posedge clk) disable iff (sys_rst)
    {cpm_enable, ext_sync, common_clk} == $past({cpm_en_q, esync_q, ccc_q}))
    else $error("control bit pins do not follow storage");

  // main scenarios the bench should reach
  // capability word read
  c_cap_read: cover property (@(posedge clk) disable iff (sys_rst) rd && hit_cap);

  // clock PM enable set through the strap gate
  c_cpm_write: cover property (@(posedge clk) disable iff (sys_rst) cpm_wr && wdata[8]);

  // both low power states enabled
  c_aspm_both: cover property (@(posedge clk) disable iff (sys_rst) aspm_reg == 2'h3);

  // control word read
  c_ctl_read: cover property (@(posedge clk) disable iff (sys_rst) rd && hit_ctl);

  // write to an unmapped address
  c_unmapped_write: cover property (@(posedge clk) disable iff (sys_rst) wr && !hit_cap && !hit_ctl);

endmodule

// [verification/plcc_board.sv]
// board model that holds the clock power management strap pins
`timescale 1ns/1ps
module plcc_board (
  input wire logic [1:0] strap_sel,
  output logic [1:0] strap_pins
);
  // pins are held by resistors, so they stay put across reset release
  assign strap_pins = strap_sel;
endmodule

// [verification/tb_top.sv]
// self-checking bench for the link capability and control register bank
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] strap_sel = 2'h0;
  logic [1:0] strap_pins;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [1:0] aspm_ctl;
  logic common_clk;
  logic ext_sync;
  logic cpm_enable;
  logic cpm_capable;
  int fails = 0;
  int total_checks = 0;
  // 50 ns period
  always #25 clk = ~clk;
  plcc_board plcc_board_i (.strap_sel(strap_sel), .strap_pins(strap_pins));
  plcc_regs plcc_regs_i (.clk(clk), .sys_rst(sys_rst), .strap_pins(strap_pins), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .aspm_ctl(aspm_ctl),
    .common_clk(common_clk), .ext_sync(ext_sync), .cpm_enable(cpm_enable),
    .cpm_capable(cpm_capable));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_t(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_t(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic close_out();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // reset with a given strap, then walk the whole bank
  task automatic run(input logic [1:0] s, input logic on);
    logic [31:0] d;
    logic [31:0] cap;
    cap = on ? 32'h00073c11 : 32'h00003c11;
    @(posedge clk);
    sys_rst <= 1'b1;
    strap_sel <= s;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd_t(8'hbc, d);
    chk(d, cap);
    chk({31'h0, cpm_capable}, {31'h0, on});
    rd_t(8'hc0, d);
    chk(d, 32'h0);
    wr_t(8'hbc, 32'hffffffff);
    rd_t(8'hbc, d);
    chk(d, cap);
    wr_t(8'hc0, 32'hffffffff);
    rd_t(8'hc0, d);
    chk(d, on ? 32'h1c3 : 32'hc3);
    chk({cpm_enable, ext_sync, common_clk, aspm_ctl}, {on, 4'hf});
    @(posedge clk);
    #1 chk(rdata, 32'h0);
    // every control code, each read back and mirrored
    for (int i = 0; i < 4; i++)
    begin
      wr_t(8'hc0, i);
      rd_t(8'hc0, d);
      chk(d, i);
      chk({30'h0, aspm_ctl}, i);
    end
    wr_t(8'h44, 32'hffffffff);
    rd_t(8'hc0, d);
    chk(d, 32'h3);
    rd_t(8'h44, d);
    chk(d, 32'h0);
  endtask
  initial
  begin
    run(2'h0, 1'b1);
    run(2'h1, 1'b0);
    run(2'h2, 1'b0);
    close_out();
  end
  // three passes take about 126 cycles
  initial
  begin
    #100000;
    fails++;
    close_out();
  end
endmodule
